// [logic/wtl_host.sv]
// Host end: queues bytes and shifts them out MSB first
`timescale 1ns/10ps
// Contract
// - Host sends power-on 04 first
// - Tables follow in order 20,21,22,25,26,27
// - Code 20 loads common-electrode table A
// - Code 21 loads white table
// - Code 22 loads black table
// - Code 25 loads common-electrode table B
// - Code 26 loads red table A
// - Code 27 loads red table B
// - Table contents come from host, batch-specific
// - Border value 57 drives border black
// - Border value 17 leaves border floating
// - Bytes shift MSB first, eight bits
// - Four-wire select stable across whole byte
// - Nine-bit mode: first bit selects destination
// - Link is write only, no readback
module wtl_host
    import wtl_pkg::*;
#(
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // User byte stream: bit 8 high means data, low means command
    input wire logic byteValid,
    output logic byteReady,
    input wire logic [8:0] byteData,
    input wire logic useNineBit,
    // Status
    output logic orderError_reg,
    output logic busy_reg,
    // Link
    wtl_link_if.host link
);
    typedef enum {ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_GAP} wtl_hstate_t;
    wtl_hstate_t state_reg;
    logic fifoValid;
    logic fifoReady;
    logic [8:0] fifoData;
    logic [8:0] shift_reg;
    logic [3:0] bitsLeft_reg;
    logic [3:0] wait_reg;
    logic sclk_reg;
    logic sdo_reg;
    logic csn_reg;
    logic dc_reg;
    logic mode_reg;
    logic [2:0] expect_reg;
    logic powered_reg;
    logic byteTaken;
    logic cmdTaken;
    logic [2:0] cmdTable;
    logic tableOpen_reg;

    // ----------------------------------------
    // Byte queue
    // ----------------------------------------
    wtl_fifo #(.WIDTH(9), .DEPTH(DEPTH)) uFifo (
        .clk(clk),
        .resetn(resetn),
        .inValid(byteValid),
        .inReady(byteReady),
        .inData(byteData),
        .outValid(fifoValid),
        .outReady(fifoReady),
        .outData(fifoData)
    );
    // Pop only while the shifter is idle, so each byte gets its own frame
    assign fifoReady = (state_reg == ST_IDLE);

    // ----------------------------------------
    // Serial shifter
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= ST_IDLE;
            shift_reg <= '0;
            bitsLeft_reg <= '0;
            wait_reg <= '0;
            sclk_reg <= 1'b0;
            sdo_reg <= 1'b0;
            csn_reg <= 1'b1;
            dc_reg <= 1'b0;
            mode_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (fifoValid) begin
                        mode_reg <= useNineBit;
                        dc_reg <= useNineBit ? 1'b0 : fifoData[8];
                        // nine-bit frame prepends the destination bit
                        shift_reg <= useNineBit ? fifoData : {fifoData[7:0], 1'b0};
                        bitsLeft_reg <= useNineBit ? 4'(BYTE_BITS + 1) : 4'(BYTE_BITS);
                        csn_reg <= 1'b0;
                        wait_reg <= 4'(CSS_CYC);
                        state_reg <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (wait_reg <= 4'h1) begin
                        // most significant bit leads
                        // Top bit is the destination bit in nine-bit frames, D7 otherwise
                        sdo_reg <= shift_reg[8];
                        wait_reg <= 4'(SCLK_HALF_CYC);
                        state_reg <= ST_LOW;
                    end else begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
                ST_LOW: begin
                    if (wait_reg <= 4'h1) begin
                        sclk_reg <= 1'b1;
                        wait_reg <= 4'(SCLK_HALF_CYC);
                        state_reg <= ST_HIGH;
                    end else begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
                ST_HIGH: begin
                    if (wait_reg <= 4'h1) begin
                        sclk_reg <= 1'b0;
                        shift_reg <= {shift_reg[7:0], 1'b0};
                        sdo_reg <= shift_reg[7];
                        bitsLeft_reg <= bitsLeft_reg - 4'h1;
                        wait_reg <= 4'(SCLK_HALF_CYC);
                        state_reg <= (bitsLeft_reg == 4'h1) ? ST_GAP : ST_LOW;
                    end else begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
                ST_GAP: begin
                    if (wait_reg <= 4'h1) begin
                        csn_reg <= 1'b1;
                        state_reg <= ST_IDLE;
                    end else begin
                        wait_reg <= wait_reg - 4'h1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------
    // Download order monitor
    // ----------------------------------------
    // Handoff terms from the queue into the shifter
    assign byteTaken = fifoValid && fifoReady;
    assign cmdTaken = byteTaken && !fifoData[8];
    assign cmdTable = tableOf(fifoData[7:0]);

    // Power-on seen; tables before it are an order fault
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            powered_reg <= 1'b0;
        end else if (cmdTaken && fifoData[7:0] == CMD_POWER_ON) begin
            powered_reg <= 1'b1;
        end
    end

    // Table position expected next in the download sequence
    // Power-on restarts the sequence, so a second download may follow
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            expect_reg <= 3'h0;
        end else if (cmdTaken && fifoData[7:0] == CMD_POWER_ON) begin
            expect_reg <= 3'h0;
        end else if (cmdTaken && cmdTable != TBL_NONE) begin
            // advances even on a fault, to keep later checks meaningful
            expect_reg <= (expect_reg == 3'(TABLE_COUNT - 1)) ? 3'h0 : expect_reg + 3'h1;
        end
    end

    // A table command stays open until its first data byte is taken
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tableOpen_reg <= 1'b0;
        end else if (byteTaken) begin
            tableOpen_reg <= !fifoData[8] && (cmdTable != TBL_NONE);
        end
    end

    // Sticky order fault: early, out of sequence, or a table left without data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            orderError_reg <= 1'b0;
        end else if (cmdTaken) begin
            if (cmdTable != TBL_NONE && (!powered_reg || cmdTable != expect_reg)) begin
                orderError_reg <= 1'b1;
            end else if (tableOpen_reg) begin
                orderError_reg <= 1'b1;
            end
        end
    end

    // Busy flag
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= (state_reg != ST_IDLE) || fifoValid;
        end
    end

    // Link drive; no read path exists
    assign link.serialClk = sclk_reg;
    assign link.serialWriteLine = sdo_reg;
    assign link.chipSelN = csn_reg;
    assign link.dataCmdSel = dc_reg;
    assign link.nineBitMode = mode_reg;
    assign link.driverResetN = resetn;
endmodule

// [logic/wtl_pkg.sv]
// Shared constants and the table decode function for the waveform table loader link
package wtl_pkg;
    // ----------------------------------------
    // Command codes
    // ----------------------------------------
    localparam logic [7:0] CMD_POWER_ON = 8'h04;
    localparam logic [7:0] CMD_TBL_COM_A = 8'h20;
    localparam logic [7:0] CMD_TBL_WHITE = 8'h21;
    localparam logic [7:0] CMD_TBL_BLACK = 8'h22;
    localparam logic [7:0] CMD_TBL_COM_B = 8'h25;
    localparam logic [7:0] CMD_TBL_RED_A = 8'h26;
    localparam logic [7:0] CMD_TBL_RED_B = 8'h27;
    localparam logic [7:0] CMD_BORDER = 8'h50;
    // ----------------------------------------
    // Border setting values
    // ----------------------------------------
    localparam logic [7:0] BORDER_BLACK = 8'h57;
    localparam logic [7:0] BORDER_FLOAT = 8'h17;
    // ----------------------------------------
    // Timing: serial clock cycle 100 ns write, clk 40 ns
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCLK_HALF_NS = 50;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CSS_NS = 60;
    localparam int CSS_CYC = (CSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BYTE_BITS = 8;
    localparam int TABLE_COUNT = 6;
    localparam logic [2:0] TBL_NONE = 3'h7;
    // Table selector for a command code, TBL_NONE when not a table
    function automatic logic [2:0] tableOf(input logic [7:0] code);
        unique case (code)
            CMD_TBL_COM_A: tableOf = 3'h0;
            CMD_TBL_WHITE: tableOf = 3'h1;
            CMD_TBL_BLACK: tableOf = 3'h2;
            CMD_TBL_COM_B: tableOf = 3'h3;
            CMD_TBL_RED_A: tableOf = 3'h4;
            CMD_TBL_RED_B: tableOf = 3'h5;
            default: tableOf = TBL_NONE;
        endcase
    endfunction
endpackage

// [logic/wtl_link_if.sv]
// Serial write link between host and driver
`timescale 1ns/10ps
interface wtl_link_if;
    logic serialClk;
    logic serialWriteLine;
    logic chipSelN;
    logic dataCmdSel;
    logic nineBitMode;
    logic driverResetN;
    modport host (output serialClk, output serialWriteLine, output chipSelN,
        output dataCmdSel, output nineBitMode, output driverResetN);
    modport device (input serialClk, input serialWriteLine, input chipSelN,
        input dataCmdSel, input nineBitMode, input driverResetN);
endinterface

// [logic/wtl_fifo.sv]
// Small valid/ready FIFO
`timescale 1ns/10ps
module wtl_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_reg;
    logic [AW-1:0] rdPtr_reg;
    logic [AW:0] count_reg;
    logic doWrite;
    logic doRead;
    logic [AW:0] countNext;

    // Handshake terms; ready itself is registered below
    assign countNext = count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
    assign outValid = (count_reg != '0);
    assign outData = mem[rdPtr_reg];
    assign doWrite = inValid && inReady;
    assign doRead = outValid && outReady;

    // Storage
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end

    // Pointers and fill count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            inReady <= 1'b1;
        end else begin
            if (doWrite) begin
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
            end
            if (doRead) begin
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
            end
            count_reg <= countNext;
            inReady <= (countNext != (AW+1)'(DEPTH));
        end
    end
endmodule

// [logic/wtl_device.sv]
// Driver end: receives bytes, stores tables, border control
`timescale 1ns/10ps
module wtl_device
    import wtl_pkg::*;
#(
    parameter int TABLE_BYTES = 64
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link
    wtl_link_if.device link,
    // Table read port for panel logic
    input wire logic [2:0] tableSel,
    input wire logic [$clog2(TABLE_BYTES)-1:0] tableAddr,
    output logic [7:0] tableData_reg,
    // Status
    output logic poweredOn_reg,
    output logic borderDrive_reg,
    output logic borderBlack_reg,
    output logic byteStrobe_reg,
    output logic [8:0] lastByte_reg
);
    localparam int AW = $clog2(TABLE_BYTES);
    logic [7:0] tables [TABLE_COUNT][TABLE_BYTES];
    logic [4:0] s1_reg;
    logic [4:0] s2_reg;
    logic sclkOld_reg;
    logic [8:0] shift_reg;
    logic [3:0] count_reg;
    logic [2:0] active_reg;
    logic [AW-1:0] wrIdx_reg;
    logic borderCmd_reg;
    logic sclkRise;
    logic gotByte;
    logic [8:0] word;

    // Pin synchronisers: mode, select, frame, clock, data; reset to the deselected idle level
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= 5'h04;
            s2_reg <= 5'h04;
        end else begin
            s1_reg <= {link.nineBitMode, link.dataCmdSel, link.chipSelN, link.serialClk,
                link.serialWriteLine};
            s2_reg <= s1_reg;
        end
    end

    assign sclkRise = s2_reg[1] && !sclkOld_reg && !s2_reg[2];
    assign gotByte = sclkRise && (count_reg == (s2_reg[4] ? 4'h8 : 4'h7));
    // nine-bit frame takes destination from first bit
    assign word = s2_reg[4] ? {shift_reg[7:0], s2_reg[0]}
                            : {s2_reg[3], shift_reg[6:0], s2_reg[0]};

    // Shift register, MSB first
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclkOld_reg <= 1'b0;
            shift_reg <= '0;
            count_reg <= '0;
        end else begin
            sclkOld_reg <= s2_reg[1];
            if (s2_reg[2]) begin
                count_reg <= '0;
            end else if (sclkRise) begin
                shift_reg <= {shift_reg[7:0], s2_reg[0]};
                count_reg <= gotByte ? 4'h0 : count_reg + 4'h1;
            end
        end
    end

    // Command decode and table load
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            poweredOn_reg <= 1'b0;
            active_reg <= TBL_NONE;
            wrIdx_reg <= '0;
            borderCmd_reg <= 1'b0;
            borderDrive_reg <= 1'b0;
            borderBlack_reg <= 1'b0;
            byteStrobe_reg <= 1'b0;
            lastByte_reg <= '0;
        end else begin
            byteStrobe_reg <= gotByte;
            if (gotByte) begin
                lastByte_reg <= word;
                if (!word[8]) begin
                    active_reg <= tableOf(word[7:0]);
                    wrIdx_reg <= '0;
                    borderCmd_reg <= (word[7:0] == CMD_BORDER);
                    if (word[7:0] == CMD_POWER_ON) begin
                        poweredOn_reg <= 1'b1;
                    end
                end else if (borderCmd_reg) begin
                    if (word[7:0] == BORDER_BLACK) begin
                        borderDrive_reg <= 1'b1;
                        borderBlack_reg <= 1'b1;
                    end else if (word[7:0] == BORDER_FLOAT) begin
                        borderDrive_reg <= 1'b0;
                        borderBlack_reg <= 1'b0;
                    end
                end else if (active_reg != TBL_NONE) begin
                    wrIdx_reg <= wrIdx_reg + 1'b1;
                end
            end
        end
    end

    // Table storage; reachable only by panel logic
    always_ff @(posedge clk) begin
        if (gotByte && word[8] && active_reg != TBL_NONE) begin
            tables[active_reg][wrIdx_reg] <= word[7:0];
        end
        tableData_reg <= (tableSel < 3'(TABLE_COUNT)) ? tables[tableSel][tableAddr] : 8'h00;
    end
endmodule

// [test/wtl_link_checker.sv]
// Framing and timing checks on the serial link between the two ends
`timescale 1ns/10ps
module wtl_link_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Link signals
    input wire logic serialClk,
    input wire logic serialWriteLine,
    input wire logic chipSelN,
    input wire logic dataCmdSel,
    input wire logic nineBitMode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    logic sclkPrev_reg;
    logic [3:0] bitCnt_reg;
    // ----------------------------------------
    // Helper logic
    // ----------------------------------------
    // Count serial clock rising edges inside one frame
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclkPrev_reg <= 1'b0;
            bitCnt_reg <= 4'h0;
        end else begin
            sclkPrev_reg <= serialClk;
            if (chipSelN) bitCnt_reg <= 4'h0;
            else if (serialClk && !sclkPrev_reg) bitCnt_reg <= bitCnt_reg + 4'h1;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_sclk_idle_low: assert property (chipSelN |-> !serialClk)
        else $error("serial clock moves outside a frame");
    a_bit_count: assert property ($rose(chipSelN) |-> bitCnt_reg == ($past(nineBitMode) ? 4'h9 : 4'h8))
        else $error("wrong number of bits in a frame");
    a_dc_steady: assert property (!chipSelN && !$past(chipSelN) |-> $stable(dataCmdSel))
        else $error("select line changed inside a frame");
    a_data_hold: assert property (serialClk && $past(serialClk) |-> $stable(serialWriteLine))
        else $error("data changed while serial clock high");
    a_sclk_high_width: assert property ($rose(serialClk) |-> serialClk [*2] ##1 !serialClk)
        else $error("serial clock high time not two cycles");
    a_sclk_low_width: assert property ($fell(serialClk) |-> !serialClk [*2])
        else $error("serial clock low time too short");
    a_cs_setup: assert property ($fell(chipSelN) |-> !serialClk [*2])
        else $error("frame select setup too short");
    a_cs_hold: assert property ($rose(chipSelN) |-> !$past(serialClk) && !$past(serialClk, 2))
        else $error("frame select hold too short");
    a_frame_bounded: assert property ($fell(chipSelN) |-> ##[1:100] $rose(chipSelN))
        else $error("frame did not close in time");
    // Main scenarios
    c_nine_bit: cover property ($rose(chipSelN) && $past(nineBitMode));
    c_data_frame: cover property ($fell(chipSelN) && dataCmdSel && !nineBitMode);
    c_cmd_frame: cover property ($fell(chipSelN) && !dataCmdSel && !nineBitMode);
endmodule

// [test/tb_top.sv]
// Self-checking bench joining host and device ends of the link
`timescale 1ns/10ps
module tb_top;
    import wtl_pkg::*;
    localparam int TB = 8;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic byteValid = 1'b0;
    logic [8:0] byteData = 9'h000;
    logic useNineBit = 1'b0;
    logic [2:0] tableSel = 3'h0;
    logic [2:0] tableAddr = 3'h0;
    logic byteReady, orderError_reg, busy_reg, poweredOn_reg;
    logic borderDrive_reg, borderBlack_reg, byteStrobe_reg;
    logic [7:0] tableData_reg;
    logic [8:0] lastByte_reg;
    // Reference model state
    logic [8:0] expQ[$];
    logic [7:0] mdl[6][TB];
    logic [7:0] codes[6] = '{CMD_TBL_COM_A, CMD_TBL_WHITE, CMD_TBL_BLACK,
        CMD_TBL_COM_B, CMD_TBL_RED_A, CMD_TBL_RED_B};
    int curTbl = -1;
    int idx = 0;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic sawFull = 1'b0;
    // ----------------------------------------
    // Clock, link and instances
    // ----------------------------------------
    always #20 clk = ~clk;
    wtl_link_if i_wtl_link_if ();
    wtl_host #(.DEPTH(4)) i_wtl_host (.clk(clk), .resetn(resetn), .byteValid(byteValid),
        .byteReady(byteReady), .byteData(byteData), .useNineBit(useNineBit),
        .orderError_reg(orderError_reg), .busy_reg(busy_reg), .link(i_wtl_link_if.host));
    wtl_device #(.TABLE_BYTES(TB)) i_wtl_device (.clk(clk), .resetn(resetn),
        .link(i_wtl_link_if.device), .tableSel(tableSel), .tableAddr(tableAddr),
        .tableData_reg(tableData_reg), .poweredOn_reg(poweredOn_reg),
        .borderDrive_reg(borderDrive_reg), .borderBlack_reg(borderBlack_reg),
        .byteStrobe_reg(byteStrobe_reg), .lastByte_reg(lastByte_reg));
    wtl_link_checker i_wtl_link_checker (.clk(clk), .resetn(resetn),
        .serialClk(i_wtl_link_if.serialClk), .serialWriteLine(i_wtl_link_if.serialWriteLine),
        .chipSelN(i_wtl_link_if.chipSelN), .dataCmdSel(i_wtl_link_if.dataCmdSel),
        .nineBitMode(i_wtl_link_if.nineBitMode));
    // ----------------------------------------
    // Reporting and comparison
    // ----------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic fail(input string msg);
        n_mismatch++;
        $display("MISMATCH t=%0t %s", $time, msg);
    endtask
    task automatic chkByte(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("received %h expected %h", got, exp));
    endtask
    task automatic chkTbl(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("table byte %h expected %h", got, exp));
    endtask
    task automatic chkFlag(input logic got, input logic exp, input string what);
        samples_checked++;
        if (got !== exp) fail($sformatf("%s is %b expected %b", what, got, exp));
    endtask
    // Every received byte is matched against the model queue
    always @(posedge clk) begin
        if (byteStrobe_reg === 1'b1) begin
            if (expQ.size() == 0) fail("byte with nothing sent");
            else chkByte(lastByte_reg, expQ.pop_front());
        end
    end
    // ----------------------------------------
    // Drivers and model
    // ----------------------------------------
    // Update the table model as the device should
    task automatic model(input logic [8:0] b);
        expQ.push_back(b);
        if (!b[8]) begin
            curTbl = -1;
            idx = 0;
            foreach (codes[i]) if (codes[i] == b[7:0]) curTbl = i;
        end else if (curTbl >= 0) begin
            mdl[curTbl][idx % TB] = b[7:0];
            idx++;
        end
    endtask
    // Offer one byte and hold it until taken; a refusal marks the buffer full
    task automatic send(input logic [8:0] b);
        int k;
        byteData = b;
        useNineBit = 1'($urandom_range(0, 1));
        byteValid = 1'b1;
        for (k = 0; k < 400; k++) begin
            @(posedge clk);
            if (byteReady === 1'b1) break;
            sawFull = 1'b1;
        end
        if (k == 400) begin
            fail("byte never taken");
            give_verdict();
        end
        model(b);
        #1;
    endtask
    // Wait until every sent byte has arrived
    task automatic drain();
        int k;
        byteValid = 1'b0;
        for (k = 0; k < 20000 && (expQ.size() != 0 || busy_reg !== 1'b0); k++) @(posedge clk);
        if (k == 20000) begin
            fail("link never went idle");
            give_verdict();
        end
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic doReset();
        resetn = 1'b0;
        expQ.delete();
        curTbl = -1;
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
        @(posedge clk);
        #1;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'h6280));
        doReset();
        // Full download, back to back so the buffer fills; one table wraps
        send({1'b0, CMD_POWER_ON});
        foreach (codes[t]) begin
            send({1'b0, codes[t]});
            for (int i = 0; i < TB + (t == 2); i++) send({1'b1, 8'($urandom)});
        end
        drain();
        chkFlag(poweredOn_reg, 1'b1, "powered");
        chkFlag(orderError_reg, 1'b0, "order error");
        chkFlag(sawFull, 1'b1, "buffer refusal");
        chkFlag(busy_reg, 1'b0, "busy");
        foreach (codes[t]) begin
            for (int a = 0; a < TB; a++) begin
                tableSel = 3'(t);
                tableAddr = 3'(a);
                repeat (2) @(posedge clk);
                #1;
                chkTbl(tableData_reg, mdl[t][a]);
            end
        end
        $display("test download done");
        // Border values
        send({1'b0, CMD_BORDER});
        send({1'b1, BORDER_BLACK});
        drain();
        chkFlag(borderDrive_reg, 1'b1, "border drive");
        chkFlag(borderBlack_reg, 1'b1, "border black");
        send({1'b0, CMD_BORDER});
        send({1'b1, BORDER_FLOAT});
        drain();
        chkFlag(borderDrive_reg, 1'b0, "border drive");
        chkFlag(borderBlack_reg, 1'b0, "border black");
        $display("test border done");
        // Out-of-order tables, then a mid-run reset and a table before power-on
        send({1'b0, CMD_TBL_RED_B});
        send({1'b0, CMD_TBL_BLACK});
        drain();
        chkFlag(orderError_reg, 1'b1, "order error");
        doReset();
        chkFlag(orderError_reg, 1'b0, "order error");
        chkFlag(poweredOn_reg, 1'b0, "powered");
        send({1'b0, CMD_TBL_COM_A});
        send({1'b1, 8'h5a});
        drain();
        chkFlag(orderError_reg, 1'b1, "order error");
        chkFlag(poweredOn_reg, 1'b0, "powered");
        $display("test order done");
        // A table command left without its data bytes
        doReset();
        send({1'b0, CMD_POWER_ON});
        send({1'b0, CMD_TBL_COM_A});
        send({1'b0, CMD_TBL_WHITE});
        drain();
        chkFlag(poweredOn_reg, 1'b1, "powered");
        chkFlag(orderError_reg, 1'b1, "order error");
        $display("test empty table done");
        give_verdict();
    end
endmodule
